// ---- design/saiu_top.sv ----
// Behaviour
// - Writing one to the suspend bit halts the core and enters suspend.
// - Enabled pending interrupt or bus activity wakes; next instruction runs first.
// - Suspend request ignored while USB bus activity is present.
// - SE0 held 12 us is a bus reset; sets bit 5.
// - Watchdog expiry after 8 ms without clear sets bit 6 and resets.
// - Bit 7 shows any pending interrupt; entry clears the serviced one.
// - Status register powers up as 00010001.
// - Start-up suspend of 96 ms; watchdog fires unless SE0 aborts it.
// - Watchdog reset loads 01XX0001, keeping power-on and bus-reset flags.
// - Any reset starts at address 0x0000; vectors are two bytes apart.
// - Vectors 0x0002 to 0x0018 in fixed source order.
// - Entry takes rest of instruction, plus 10 call and 5 jump cycles.
// - Bus reset clears device addresses and hub port registers.
// - Bus-reset interrupt raised when SE0 ends; bus reset aborts start-up.
// - Two periodic timer sources, 128 us and 1.024 ms.
// - Endpoint interrupts fire on the final acknowledge of a transaction.
// - Hub interrupt on unforced connect change, or on babble or resume of an enabled port.
// - Current-sink pins: enabled edge interrupts, per-pin polarity, owner blocks.
// - GPIO pins: enabled edge interrupts, per-port polarity, owner blocks.
// - Parallel host port owns GPIO vector, enabled only by global bit 5.
`include "saiu_cfg.svh"

module saiu_top #(
  parameter int unsigned WDT_CYCLES   = `SAIU_T_WATCH_US * `SAIU_CLK_MHZ,
  parameter int unsigned START_CYCLES = `SAIU_T_START_US * `SAIU_CLK_MHZ
) (
  input  wire logic                CLOCK_IN,
  input  wire logic                RST_IN,
  input  wire saiu_pkg::saiu_bus_t BUS_IN,
  output logic [7:0]               RDATA_OUT,
  input  wire logic                CPU_INSTR_END_IN,
  input  wire logic                CPU_EI_IN,
  input  wire logic                CPU_DI_IN,
  input  wire logic                CPU_RETI_IN,
  input  wire logic                CPU_HALT_INSTR_IN,
  input  wire logic                WDT_CLEAR_IN,
  output logic                     CPU_RUN_OUT,
  output saiu_pkg::saiu_vec_t      VEC_OUT,
  output logic                     ENTRY_BUSY_OUT,
  output logic                     SUSPEND_OUT,
  output logic                     WDT_RESET_OUT,
  input  wire logic                USB_DP_IN,
  input  wire logic                USB_DM_IN,
  input  wire logic                USB_ACTIVITY_IN,
  input  wire logic [4:0]          EP_IN_ACK_IN,
  input  wire logic [4:0]          EP_OUT_ACK_IN,
  input  wire saiu_pkg::saiu_hub_t HUB_IN,
  input  wire logic [7:0]          DAC_PIN_IN,
  input  wire logic [30:0]         GPIO_PIN_IN,
  input  wire logic                PHST_EVENT_IN,
  input  wire logic                I2C_EVENT_IN,
  output logic [7:0]               USB_ADDR_A_OUT,
  output logic [7:0]               USB_ADDR_B_OUT,
  output logic [3:0]               HUB_PORT_EN_OUT,
  output logic                     HUB_REGS_CLEAR_OUT
);
  import saiu_pkg::*;

  localparam int SE0_CYC  = (`SAIU_T_SE0_NS * `SAIU_CLK_MHZ + 999) / 1000;
  localparam int TICK_CYC = `SAIU_T_TICK_NS * `SAIU_CLK_MHZ / 1000;
  localparam int NSRC     = `SAIU_NSRC;

  // Status and control bits
  logic            run;
  logic            susp;
  logic            por;
  logic            brst;
  logic            wdg;
  logic            ies;
  logic            wake_hold;
  // Configuration
  logic [7:0]      gie;
  logic [4:0]      epie;
  logic [7:0]      dacie;
  logic [7:0]      dacpol;
  logic [31:0]     gpie;
  logic [3:0]      gppol;
  logic            phst_en;
  logic [7:0]      addr_a;
  logic [7:0]      addr_b;
  logic [3:0]      port_en;
  // Event sources
  logic [8:0]      se0_cnt;
  logic            se0;
  logic            se0_seen;
  logic            brst_det;
  logic            brst_irq_ev;
  logic [11:0]     tick_cnt;
  logic [2:0]      slow_cnt;
  logic            tick_fast;
  logic            tick_slow;
  logic [23:0]     wdt_cnt;
  logic            wdt_fire;
  logic [23:0]     start_cnt;
  logic            starting;
  logic            start_end;
  logic            dac_ev;
  logic            gpio_ev;
  logic            gpio_vec_ev;
  logic            hub_ev;
  logic [4:0]      ep_ev;
  // Interrupt arbitration
  logic [NSRC-1:0] src_ev;
  logic [NSRC-1:0] src_en;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] elig;
  logic [NSRC-1:0] next_pend;
  logic [3:0]      sel;
  logic            take;
  logic            wake;
  saiu_entry_t     state;
  logic [3:0]      cyc;
  logic [15:0]     entry_addr;
  logic [30:0]     gp_pol_pins;
  logic [7:0]      rd_val;

  function automatic logic [3:0] lowest(input logic [NSRC-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // ---------------- Bus reset detection ----------------
  assign se0      = ~USB_DP_IN & ~USB_DM_IN;
  assign brst_det = se0 && !se0_seen && se0_cnt == 9'(SE0_CYC - 1);
  assign brst_irq_ev = se0_seen && !se0;

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      se0_cnt  <= 9'h000;
      se0_seen <= 1'b0;
    end else if (!se0) begin
      se0_cnt  <= 9'h000;
      se0_seen <= 1'b0;
    end else begin
      if (!se0_seen) begin
        se0_cnt <= se0_cnt + 9'h001;
      end
      if (brst_det) begin
        se0_seen <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      HUB_REGS_CLEAR_OUT <= 1'b0;
    end else begin
      HUB_REGS_CLEAR_OUT <= brst_det;
    end
  end

  // ---------------- Periodic timers, stopped in suspend ----------------
  assign tick_fast = !susp && tick_cnt == 12'(TICK_CYC - 1);
  assign tick_slow = tick_fast && slow_cnt == 3'(`SAIU_SLOW_DIV - 1);

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tick_cnt <= 12'h000;
      slow_cnt <= 3'h0;
    end else if (!susp) begin
      tick_cnt <= tick_fast ? 12'h000 : tick_cnt + 12'h001;
      if (tick_fast) begin
        slow_cnt <= slow_cnt + 3'h1;
      end
    end
  end

  // ---------------- Watchdog and start-up delay ----------------
  assign wdt_fire  = !susp && wdt_cnt == 24'(WDT_CYCLES - 1);
  assign start_end = starting && (start_cnt == 24'(START_CYCLES - 1) || brst_det);

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wdt_cnt <= 24'h000000;
    end else if (WDT_CLEAR_IN || wdt_fire) begin
      wdt_cnt <= 24'h000000;
    end else if (!susp) begin
      wdt_cnt <= wdt_cnt + 24'h000001;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      start_cnt <= 24'h000000;
      starting  <= 1'b1;
    end else if (start_end) begin
      starting  <= 1'b0;
    end else if (starting) begin
      start_cnt <= start_cnt + 24'h000001;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      WDT_RESET_OUT <= 1'b0;
    end else begin
      WDT_RESET_OUT <= wdt_fire;
    end
  end

  // ---------------- Pin, endpoint and hub sources ----------------
  assign gp_pol_pins = {{7{gppol[3]}}, {8{gppol[2]}}, {8{gppol[1]}}, {8{gppol[0]}}};

  saiu_pin_irq #(.W(8)) u_dac_irq (
    .clk_in    (CLOCK_IN),
    .rst_in    (RST_IN),
    .pin_in    (DAC_PIN_IN),
    .en_in     (dacie),
    .pol_in    (dacpol),
    .event_out (dac_ev)
  );

  saiu_pin_irq #(.W(31)) u_gpio_irq (
    .clk_in    (CLOCK_IN),
    .rst_in    (RST_IN),
    .pin_in    (GPIO_PIN_IN),
    .en_in     (gpie[30:0]),
    .pol_in    (gp_pol_pins),
    .event_out (gpio_ev)
  );

  assign gpio_vec_ev = phst_en ? PHST_EVENT_IN : gpio_ev;
  assign ep_ev       = EP_IN_ACK_IN | EP_OUT_ACK_IN;
  assign hub_ev      = |(HUB_IN.connect_chg & ~HUB_IN.forced)
                     | |((HUB_IN.babble | HUB_IN.resume) & port_en);

  // ---------------- Pending flags and arbitration ----------------
  // Index 0 is vector 1 (bus reset) up to index 11, vector 12
  assign src_ev = {I2C_EVENT_IN, gpio_vec_ev, dac_ev, hub_ev, ep_ev,
                   tick_slow, tick_fast, brst_irq_ev};
  assign src_en = {gie[6], gie[`SAIU_GIE_GPIO], gie[4], gie[3], epie,
                   gie[2], gie[1], gie[0]};
  assign elig   = pend & src_en;
  assign sel    = lowest(elig);
  assign take   = state == ST_IDLE && ies && |elig && CPU_INSTR_END_IN
                  && !wake_hold && !starting && run && !susp;
  assign wake   = susp && (USB_ACTIVITY_IN || |elig);
  assign entry_addr = 16'((32'(sel) + 1) * `SAIU_VEC_STEP);

  always_comb begin
    next_pend = pend;
    if (take) begin
      next_pend[sel] = 1'b0;
    end
    next_pend = next_pend | src_ev;
    if (wdt_fire) begin
      next_pend = '0;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pend <= '0;
    end else begin
      pend <= next_pend;
    end
  end

  // ---------------- Interrupt entry sequence ----------------
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state   <= ST_IDLE;
      cyc     <= 4'h0;
      ies     <= 1'b0;
      VEC_OUT <= '0;
    end else begin
      VEC_OUT.load <= 1'b0;
      if (wdt_fire || CPU_HALT_INSTR_IN) begin
        state <= ST_IDLE;
        ies   <= 1'b0;
        // Start-up end must still restart the core when the watchdog fires with it
        if ((wdt_fire && !starting) || start_end) begin
          VEC_OUT.load <= 1'b1;
          VEC_OUT.addr <= `SAIU_RESET_VEC;
        end
      end else if (start_end) begin
        VEC_OUT.load <= 1'b1;
        VEC_OUT.addr <= `SAIU_RESET_VEC;
      end else begin
        case (state)
          ST_IDLE: begin
            if (take) begin
              state        <= ST_CALL;
              cyc          <= 4'(`SAIU_CALL_CYC - 1);
              ies          <= 1'b0;
              VEC_OUT.addr <= entry_addr;
            end else if (CPU_EI_IN || CPU_RETI_IN) begin
              ies <= 1'b1;
            end else if (CPU_DI_IN) begin
              ies <= 1'b0;
            end
          end
          ST_CALL: begin
            if (cyc == 4'h0) begin
              state <= ST_JUMP;
              cyc   <= 4'(`SAIU_JMP_CYC - 1);
            end else begin
              cyc <= cyc - 4'h1;
            end
          end
          ST_JUMP: begin
            if (cyc == 4'h0) begin
              state        <= ST_IDLE;
              VEC_OUT.load <= 1'b1;
            end else begin
              cyc <= cyc - 4'h1;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign ENTRY_BUSY_OUT = state != ST_IDLE;
  assign CPU_RUN_OUT    = run && !susp && !starting;
  assign SUSPEND_OUT    = susp;

  // ---------------- Status and control register ----------------
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      run  <= 1'(`SAIU_PSC_RST >> `SAIU_B_RUN);
      por  <= 1'b1;
      susp <= 1'b0;
      brst <= 1'b0;
      wdg  <= 1'b0;
    end else if (wdt_fire) begin
      run  <= 1'b1;
      susp <= 1'b0;
      wdg  <= 1'b1;
      brst <= brst | brst_det;
    end else if (CPU_HALT_INSTR_IN) begin
      run  <= 1'b0;
      susp <= 1'b0;
      por  <= 1'b0;
      wdg  <= 1'b0;
      brst <= brst_det;
    end else begin
      if (BUS_IN.wr && BUS_IN.addr == `SAIU_A_PSC) begin
        run  <= BUS_IN.wdata[`SAIU_B_RUN];
        por  <= BUS_IN.wdata[`SAIU_B_POR];
        wdg  <= BUS_IN.wdata[`SAIU_B_WDG];
        brst <= BUS_IN.wdata[`SAIU_B_BRST] | brst_det;
        susp <= BUS_IN.wdata[`SAIU_B_SUSP] & ~USB_ACTIVITY_IN;
      end else begin
        if (brst_det) begin
          brst <= 1'b1;
        end
        if (wake) begin
          susp <= 1'b0;
        end
      end
    end
  end

  // After wake the instruction following the suspend write runs first
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wake_hold <= 1'b0;
    end else if (wake) begin
      wake_hold <= 1'b1;
    end else if (CPU_INSTR_END_IN || wdt_fire) begin
      wake_hold <= 1'b0;
    end
  end

  // ---------------- Configuration registers ----------------
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      gie     <= 8'h00;
      epie    <= 5'h00;
      dacie   <= 8'h00;
      dacpol  <= 8'h00;
      gppol   <= 4'h0;
      phst_en <= 1'b0;
    end else if (BUS_IN.wr) begin
      case (BUS_IN.addr)
        `SAIU_A_GIE:    gie     <= BUS_IN.wdata;
        `SAIU_A_EPIE:   epie    <= BUS_IN.wdata[4:0];
        `SAIU_A_DACIE:  dacie   <= BUS_IN.wdata;
        `SAIU_A_DACPOL: dacpol  <= BUS_IN.wdata;
        `SAIU_A_GPPOL:  gppol   <= BUS_IN.wdata[3:0];
        `SAIU_A_PHST:   phst_en <= BUS_IN.wdata[0];
        default: begin
        end
      endcase
    end
  end

  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_gpie
      always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          gpie[8*p +: 8] <= 8'h00;
        end else if (BUS_IN.wr && BUS_IN.addr == `SAIU_A_GPIE0 + 8'(p)) begin
          gpie[8*p +: 8] <= BUS_IN.wdata;
        end
      end
    end
  endgenerate

  // Device addresses and port enables, cleared by bus reset
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      addr_a  <= 8'h00;
      addr_b  <= 8'h00;
      port_en <= 4'h0;
    end else if (brst_det) begin
      addr_a  <= 8'h00;
      addr_b  <= 8'h00;
      port_en <= 4'h0;
    end else if (wdt_fire) begin
      addr_a <= 8'h00;
      addr_b <= 8'h00;
    end else if (BUS_IN.wr) begin
      case (BUS_IN.addr)
        `SAIU_A_ADDR_A:  addr_a  <= BUS_IN.wdata;
        `SAIU_A_ADDR_B:  addr_b  <= BUS_IN.wdata;
        `SAIU_A_PORT_EN: port_en <= BUS_IN.wdata[3:0];
        default: begin
        end
      endcase
    end
  end

  assign USB_ADDR_A_OUT  = addr_a;
  assign USB_ADDR_B_OUT  = addr_b;
  assign HUB_PORT_EN_OUT = port_en;

  // ---------------- Read path ----------------
  always_comb begin
    rd_val = 8'h00;
    case (BUS_IN.addr)
      `SAIU_A_PSC: begin
        rd_val[`SAIU_B_PEND] = |pend;
        rd_val[`SAIU_B_WDG]  = wdg;
        rd_val[`SAIU_B_BRST] = brst;
        rd_val[`SAIU_B_POR]  = por;
        rd_val[`SAIU_B_SUSP] = susp;
        rd_val[`SAIU_B_IES]  = ies;
        rd_val[`SAIU_B_RUN]  = run;
      end
      `SAIU_A_GIE:     rd_val = gie;
      `SAIU_A_EPIE:    rd_val = {3'h0, epie};
      `SAIU_A_DACIE:   rd_val = dacie;
      `SAIU_A_DACPOL:  rd_val = dacpol;
      `SAIU_A_GPIE0:   rd_val = gpie[7:0];
      8'h25:           rd_val = gpie[15:8];
      8'h26:           rd_val = gpie[23:16];
      8'h27:           rd_val = {1'b0, gpie[30:24]};
      `SAIU_A_GPPOL:   rd_val = {4'h0, gppol};
      `SAIU_A_PHST:    rd_val = {7'h00, phst_en};
      `SAIU_A_ADDR_A:  rd_val = addr_a;
      `SAIU_A_ADDR_B:  rd_val = addr_b;
      `SAIU_A_PORT_EN: rd_val = {4'h0, port_en};
      default:         rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= 8'h00;
    end else begin
      RDATA_OUT <= BUS_IN.rd ? rd_val : 8'h00;
    end
  end

endmodule // saiu_top

// ---- design/saiu_cfg.svh ----
`ifndef SAIU_CFG_SVH
`define SAIU_CFG_SVH

`define SAIU_CLK_MHZ      25

`define SAIU_A_ADDR_A     8'h10
`define SAIU_A_GIE        8'h20
`define SAIU_A_EPIE       8'h21
`define SAIU_A_DACIE      8'h22
`define SAIU_A_DACPOL     8'h23
`define SAIU_A_GPIE0      8'h24
`define SAIU_A_GPPOL      8'h28
`define SAIU_A_PHST       8'h29
`define SAIU_A_ADDR_B     8'h40
`define SAIU_A_PORT_EN    8'h49
`define SAIU_A_PSC        8'hff

`define SAIU_PSC_RST      8'h11
`define SAIU_B_RUN        0
`define SAIU_B_IES        2
`define SAIU_B_SUSP       3
`define SAIU_B_POR        4
`define SAIU_B_BRST       5
`define SAIU_B_WDG        6
`define SAIU_B_PEND       7
`define SAIU_GIE_GPIO     5

`define SAIU_T_SE0_NS     12000
`define SAIU_T_TICK_NS    128000
`define SAIU_SLOW_DIV     8
`define SAIU_T_WATCH_US   8000
`define SAIU_T_START_US   96000
`define SAIU_CALL_CYC     10
`define SAIU_JMP_CYC      5

`define SAIU_RESET_VEC    16'h0000
`define SAIU_VEC_STEP     2
`define SAIU_NSRC         12

`endif

// ---- design/saiu_pkg.sv ----
package saiu_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALL = 2'b01,
    ST_JUMP = 2'b10
  } saiu_entry_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } saiu_bus_t;

  typedef struct packed {
    logic [3:0] connect_chg;
    logic [3:0] babble;
    logic [3:0] resume;
    logic [3:0] forced;
  } saiu_hub_t;

  typedef struct packed {
    logic        load;
    logic [15:0] addr;
  } saiu_vec_t;

endpackage

// ---- design/saiu_pin_irq.sv ----
module saiu_pin_irq #(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] pin_in,
  input  wire logic [W-1:0] en_in,
  input  wire logic [W-1:0] pol_in,
  output logic              event_out
);
  logic [W-1:0] act;
  logic [W-1:0] act_q;
  logic [W-1:0] rise;
  logic [W-1:0] owner;
  logic         hold;

  // Polarity 1 means a rising edge triggers, 0 a falling edge
  assign act  = ~(pin_in ^ pol_in);
  assign rise = act & ~act_q & en_in;
  assign hold = |owner;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          act_q[i] <= 1'b0;
          owner[i] <= 1'b0;
        end else begin
          act_q[i] <= act[i];
          // Owner blocks the others until inactive or disabled
          owner[i] <= (owner[i] & act[i] & en_in[i]) | (~hold & rise[i]);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      event_out <= 1'b0;
    end else begin
      event_out <= ~hold & (|rise);
    end
  end

endmodule // saiu_pin_irq

// ---- test/saiu_top_sva.sv ----
module saiu_top_sva (
  input wire logic                CLOCK_IN,
  input wire logic                RST_IN,
  input wire saiu_pkg::saiu_bus_t BUS_IN,
  input wire saiu_pkg::saiu_vec_t VEC_OUT,
  input wire logic                ENTRY_BUSY_OUT,
  input wire logic                SUSPEND_OUT,
  input wire logic                CPU_RUN_OUT,
  input wire logic                WDT_RESET_OUT,
  input wire logic                USB_DP_IN,
  input wire logic                USB_DM_IN,
  input wire logic                USB_ACTIVITY_IN,
  input wire logic [7:0]          USB_ADDR_A_OUT,
  input wire logic [7:0]          USB_ADDR_B_OUT,
  input wire logic [3:0]          HUB_PORT_EN_OUT,
  input wire logic                HUB_REGS_CLEAR_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  import saiu_pkg::*;
  logic [15:0] se0_cnt;
  logic        se0_seen;
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      se0_cnt <= 16'h0;
    end else begin
      se0_cnt <= (USB_DP_IN | USB_DM_IN) ? 16'h0 : se0_cnt + 16'h1;
    end
  end
  // Remembers whether the current SE0 stretch has been recognised
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      se0_seen <= 1'b0;
    end else begin
      se0_seen <= !(USB_DP_IN | USB_DM_IN) && (se0_seen | HUB_REGS_CLEAR_OUT);
    end
  end
  chk_entry_len: assert property ($rose(ENTRY_BUSY_OUT) |-> ##15 VEC_OUT.load)
    else $error("vector load not 15 cycles after entry start");
  chk_vec_table: assert property (VEC_OUT.load |-> !VEC_OUT.addr[0] && VEC_OUT.addr <= 16'h18)
    else $error("vector address outside table");
  chk_wdt_vector: assert property ($past(CPU_RUN_OUT) && WDT_RESET_OUT |->
    VEC_OUT.load && VEC_OUT.addr == 16'h0)
    else $error("watchdog reset did not restart at zero");
  chk_brst_clear: assert property (HUB_REGS_CLEAR_OUT |-> USB_ADDR_A_OUT == 8'h0 &&
    USB_ADDR_B_OUT == 8'h0 && HUB_PORT_EN_OUT == 4'h0)
    else $error("bus reset left registers set");
  chk_se0_min: assert property (HUB_REGS_CLEAR_OUT |-> se0_cnt >= 16'h12a)
    else $error("bus reset recognised too early");
  chk_se0_max: assert property (se0_cnt == 16'h190 |-> se0_seen)
    else $error("bus reset not recognised after 16 us");
  chk_wake_act: assert property (USB_ACTIVITY_IN |-> ##[1:2] !SUSPEND_OUT)
    else $error("suspended despite bus activity");
  chk_susp_halt: assert property (SUSPEND_OUT |-> !CPU_RUN_OUT)
    else $error("core runs while suspended");
  chk_susp_req: assert property (BUS_IN.wr && BUS_IN.addr == 8'hff && BUS_IN.wdata[3] &&
    !USB_ACTIVITY_IN |=> SUSPEND_OUT)
    else $error("suspend request not taken");
endmodule // saiu_top_sva

bind saiu_top saiu_top_sva i_sva (
  .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .BUS_IN(BUS_IN), .VEC_OUT(VEC_OUT),
  .ENTRY_BUSY_OUT(ENTRY_BUSY_OUT), .SUSPEND_OUT(SUSPEND_OUT), .CPU_RUN_OUT(CPU_RUN_OUT),
  .WDT_RESET_OUT(WDT_RESET_OUT), .USB_DP_IN(USB_DP_IN), .USB_DM_IN(USB_DM_IN),
  .USB_ACTIVITY_IN(USB_ACTIVITY_IN), .USB_ADDR_A_OUT(USB_ADDR_A_OUT),
  .USB_ADDR_B_OUT(USB_ADDR_B_OUT), .HUB_PORT_EN_OUT(HUB_PORT_EN_OUT),
  .HUB_REGS_CLEAR_OUT(HUB_REGS_CLEAR_OUT)
);

// ---- test/saiu_core_model.sv ----
module saiu_core_model (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic run_in,
  input  wire logic busy_in,
  input  wire logic slow_in,
  input  wire logic hold_in,
  output logic      instr_end_out,
  output logic      wdt_clear_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] step;
  logic [5:0] wd_step;
  // Instructions end every 2 or 5 cycles, only while the core runs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      step <= 3'h0;
      instr_end_out <= 1'b0;
    end else begin
      instr_end_out <= 1'b0;
      if (run_in && !busy_in) begin
        step <= (step == (slow_in ? 3'h4 : 3'h1)) ? 3'h0 : step + 3'h1;
        instr_end_out <= step == 3'h0;
      end
    end
  end
  // Firmware clears the watchdog every 64 cycles while the core runs, unless told to stop
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wd_step <= 6'h0;
      wdt_clear_out <= 1'b0;
    end else begin
      wd_step <= wd_step + 6'h1;
      wdt_clear_out <= run_in && !hold_in && wd_step == 6'h0;
    end
  end
endmodule // saiu_core_model

// ---- test/status_and_interrupt_unit_bench.sv ----
module status_and_interrupt_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import saiu_pkg::*;
  typedef struct packed {
    logic [7:0]  ra;
    logic [7:0]  rd;
    logic [3:0]  src;
    logic [15:0] vec;
  } saiu_row_t;
  logic        clk, rst, ie, ei, reti, wclr, run, busy, susp, wdg;
  logic        dp, dm, act, phst, i2c, clr, slow, hold;
  saiu_bus_t   bus;
  saiu_vec_t   vec;
  saiu_hub_t   hub;
  logic [7:0]  rdata, dac, adra, adrb;
  logic [4:0]  epi, epo;
  logic [30:0] gpio;
  logic [3:0]  pen;
  int          fail_count, n_checks, i, hits;
  saiu_row_t   rows [12] = '{
    '{8'h21, 8'h1f, 4'h0, 16'h08}, '{8'h21, 8'h1f, 4'h1, 16'h0a},
    '{8'h21, 8'h1f, 4'h2, 16'h0c}, '{8'h21, 8'h1f, 4'h3, 16'h0e},
    '{8'h21, 8'h1f, 4'h4, 16'h10}, '{8'h20, 8'h08, 4'h5, 16'h12},
    '{8'h20, 8'h10, 4'h6, 16'h14}, '{8'h20, 8'h20, 4'h7, 16'h16},
    '{8'h29, 8'h01, 4'h8, 16'h16}, '{8'h20, 8'h40, 4'h9, 16'h18},
    '{8'h20, 8'h02, 4'ha, 16'h04}, '{8'h20, 8'h04, 4'ha, 16'h06}};

  saiu_top #(.WDT_CYCLES(200), .START_CYCLES(1000)) i_dut (
    .CLOCK_IN(clk), .RST_IN(rst), .BUS_IN(bus), .RDATA_OUT(rdata),
    .CPU_INSTR_END_IN(ie), .CPU_EI_IN(ei), .CPU_DI_IN(1'b0), .CPU_RETI_IN(reti),
    .CPU_HALT_INSTR_IN(1'b0), .WDT_CLEAR_IN(wclr), .CPU_RUN_OUT(run), .VEC_OUT(vec),
    .ENTRY_BUSY_OUT(busy), .SUSPEND_OUT(susp), .WDT_RESET_OUT(wdg), .USB_DP_IN(dp),
    .USB_DM_IN(dm), .USB_ACTIVITY_IN(act), .EP_IN_ACK_IN(epi), .EP_OUT_ACK_IN(epo),
    .HUB_IN(hub), .DAC_PIN_IN(dac), .GPIO_PIN_IN(gpio), .PHST_EVENT_IN(phst),
    .I2C_EVENT_IN(i2c), .USB_ADDR_A_OUT(adra), .USB_ADDR_B_OUT(adrb),
    .HUB_PORT_EN_OUT(pen), .HUB_REGS_CLEAR_OUT(clr));

  saiu_core_model i_core (
    .clk_in(clk), .rst_in(rst), .run_in(run), .busy_in(busy), .slow_in(slow),
    .hold_in(hold), .instr_end_out(ie), .wdt_clear_out(wclr));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 check(20'(rdata & m), 20'(e));
  endtask

  task automatic ack(input bit use_reti);
    @(posedge clk);
    if (use_reti) reti <= 1'b1;
    else ei <= 1'b1;
    @(posedge clk);
    {ei, reti} <= 2'b00;
  endtask

  task automatic poke(input logic [3:0] s);
    @(posedge clk);
    case (s)
      4'h5: hub.connect_chg <= 4'h1;
      4'h6: dac <= 8'h01;
      4'h7: gpio <= 31'h1;
      4'h8: phst <= 1'b1;
      4'h9: i2c <= 1'b1;
      4'ha: ;
      default: if (s[0]) epo <= 5'(1 << s);
               else epi <= 5'(1 << s);
    endcase
    @(posedge clk);
    {epi, epo, hub.connect_chg, phst, i2c} <= '0;
  endtask

  task automatic wait_load(input logic [15:0] e);
    for (int k = 0; k < 30000 && vec.load !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    check(20'({vec.load, vec.addr}), 20'({1'b1, e}));
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    {rst, dp} = 2'b11;
    {ei, reti, dm, act, phst, i2c, slow, hold} = '0;
    {bus, hub, epi, epo, dac, gpio} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(8'hff, 8'hff, 8'h11);
    rd(8'h30, 8'hff, 8'h00);
    check(20'(run), 20'h0);
    wait_load(16'h0);
    rd(8'hff, 8'hff, 8'h51);
    $display("test reset done");
    wr(8'h21, 8'h1f);
    wr(8'h22, 8'h01);
    wr(8'h23, 8'h01);
    wr(8'h24, 8'h01);
    wr(8'h28, 8'h01);
    @(posedge clk);
    epi <= 5'h11;
    @(posedge clk);
    epi <= 5'h00;
    rd(8'hff, 8'hff, 8'hd1);
    ack(1'b1);
    wait_load(16'h08);
    ack(1'b1);
    wait_load(16'h10);
    rd(8'hff, 8'hff, 8'h51);
    $display("test priority done");
    foreach (rows[r]) begin
      slow <= r[0];
      wr(rows[r].ra, rows[r].rd);
      poke(rows[r].src);
      ack(1'b0);
      wait_load(rows[r].vec);
    end
    $display("test vectors done");
    wr(8'h20, 8'h00);
    act <= 1'b1;
    wr(8'hff, 8'h09);
    #1 check(20'(susp), 20'h0);
    act <= 1'b0;
    wr(8'hff, 8'h09);
    #1 check(20'({susp, run}), 20'h2);
    repeat (20) @(posedge clk);
    #1 check(20'(susp), 20'h1);
    act <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check(20'(susp), 20'h0);
    act <= 1'b0;
    $display("test suspend done");
    wr(8'h10, 8'h55);
    wr(8'h40, 8'h66);
    wr(8'h49, 8'h0f);
    wr(8'h20, 8'h01);
    ack(1'b0);
    dp <= 1'b0;
    repeat (420) begin
      @(posedge clk);
      #1 if (vec.load === 1'b1) hits++;
    end
    check(20'(hits), 20'h0);
    check({adra, adrb, pen}, 20'h0);
    dp <= 1'b1;
    wait_load(16'h02);
    rd(8'hff, 8'h7f, 8'h21);
    $display("test bus reset done");
    hold <= 1'b1;
    for (i = 0; i < 600 && wdg !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check(20'({vec.load, vec.addr}), 20'h10000);
    hold <= 1'b0;
    rd(8'hff, 8'hff, 8'h61);
    $display("test watchdog done");
    tally_and_finish();
  end
endmodule // status_and_interrupt_unit_bench
